// File: common/adpr_pkg.sv
/*
 Shared constants for the command interpreter and its host end.
 Assumes one 40 MHz clock and synchronous active-high reset at both ends.
*/
package adpr_pkg;
   // -------------------------------------------------------------
   // Opcodes
   // -------------------------------------------------------------
   localparam logic [7:0] ADPR_OP_PAUSE  = 8'h01; // Selective idle
   localparam logic [7:0] ADPR_OP_READ   = 8'h02; // Zone read
   localparam logic [7:0] ADPR_OP_RANDOM = 8'h1B; // Random fetch
   // -------------------------------------------------------------
   // Result codes and patterns
   // -------------------------------------------------------------
   localparam logic [7:0] ADPR_OK        = 8'h00; // Success byte
   localparam logic [7:0] ADPR_ERR_PARSE = 8'h03; // Parameter error
   localparam logic [7:0] ADPR_ERR_EXEC  = 8'h0F; // Execution error
   localparam logic [7:0] ADPR_TEST_HI   = 8'hFF; // Test pattern high pair
   localparam logic [7:0] ADPR_TEST_LO   = 8'h00; // Test pattern low pair
   // -------------------------------------------------------------
   // Zones and field positions
   // -------------------------------------------------------------
   localparam logic [1:0] ADPR_ZONE_CFG  = 2'h0;
   localparam logic [1:0] ADPR_ZONE_OTP  = 2'h1;
   localparam logic [1:0] ADPR_ZONE_DATA = 2'h2;
   localparam int ADPR_SIZE_BIT   = 7;      // Param1 bit: 32-byte read
   localparam int ADPR_MODE_NOUPD = 0;      // Param1 bit: keep seed
   localparam int ADPR_SC_SECRET  = 7;      // Slot access word: secret
   localparam int ADPR_SC_ENCRD   = 6;      // Slot access word: encrypted read
   localparam int ADPR_SC_RKEY_LO = 0;      // Slot access word: read key index
   localparam int ADPR_CFG_WORDS  = 22;     // Configuration zone words
   localparam int ADPR_OTP_WORDS  = 16;     // OTP zone words
   localparam int ADPR_DATA_WORDS = 128;    // Data zone words
   localparam logic [7:0] ADPR_OTP_LEGACY = 8'h00; // Legacy policy
   localparam logic [7:0] ADPR_OTP_RO     = 8'hAA; // Read-only policy
   localparam int ADPR_SHORT = 4;           // Short read byte count
   localparam int ADPR_LONG  = 32;          // Long read byte count
endpackage

// File: common/adpr_if.sv
/*
 Command/answer carrier between host end and device end.
 Assumes both ends share clk; a command is one beat, answers stream bytewise.
*/
interface adpr_if;
   logic        cmd_valid;   // Host offers a command
   logic        cmd_ready;   // Device accepts it
   logic [7:0]  cmd_opcode;  // Opcode
   logic [7:0]  cmd_param1;  // First parameter
   logic [15:0] cmd_param2;  // Second parameter
   logic        rsp_valid;   // Answer byte present
   logic [7:0]  rsp_byte;    // Answer byte
   logic        rsp_last;    // Final byte of the answer
   modport device (input cmd_valid, cmd_opcode, cmd_param1, cmd_param2,
                   output cmd_ready, rsp_valid, rsp_byte, rsp_last);
   modport host   (output cmd_valid, cmd_opcode, cmd_param1, cmd_param2,
                   input cmd_ready, rsp_valid, rsp_byte, rsp_last);
endinterface

// File: design/adpr_device.sv
/*
 Device end: executes selective idle, random fetch and zone read.
 Assumes the host never sends a new command while an answer streams out.
*/
// Behaviour
// - Selector mismatch: idle now, no answer
// - Selector match: answer single 0x00
// - Selective idle never enters sleep
// - Host sends idle with zero param2
// - Random fetch answers 32 generator bytes
// - Locked config: mode bit0 chooses seed refresh or keep
// - Worn-out seed: refresh request errors
// - Unlocked config: fixed FF FF 00 00 pattern
// - Random mixes entropy with shared seed
// - Read opcode, zone bits, size bit
// - Word address; long ignores low three; range
// - Config always readable except forbidden words
// - OTP read locked-only, policy guards words 0-1
// - Legacy OTP policy: only short reads
// - Data read needs lock and slot flags
// - Encrypted read XORs with scratch key
// - Encrypted read needs valid random-derived key
// - Success returns 4 or 32 bytes
// - Nonce fills scratch key, marks origin
module adpr_device
   import adpr_pkg::*;
#(
   parameter int SEED_LIFE = 1000   // Seed refreshes allowed
)(
   input  wire logic        clk,
   input  wire logic        srst,
   adpr_if.device           bus,
   input  wire logic [7:0]  unit_select,       // Stored unit-select byte
   input  wire logic        config_locked,     // Configuration zone locked
   input  wire logic        otp_locked,        // OTP zone locked
   input  wire logic        data_locked,       // Data zone locked
   input  wire logic [7:0]  otp_zone_policy,   // OTP policy byte
   input  wire logic [31:0] entropy,           // Raw entropy source word
   input  wire logic        nonce_load,        // Nonce result strobe
   input  wire logic        nonce_passthru,    // Loaded by pass-through
   input  wire logic [255:0] nonce_value,      // Nonce result
   input  wire logic        digest_load,       // Digest generate strobe
   input  wire logic [3:0]  digest_slot,       // Slot used by digest
   input  wire logic [255:0] digest_value,     // Digest result
   output logic             idle,              // Device idled by selector
   output logic [31:0]      seed_out           // Current seed (observation)
);
   // Elaboration check: a zero seed life would wear the seed out before use
   if (SEED_LIFE < 1)
      $error("SEED_LIFE must be positive");

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [7:0]   cfg_mem  [ADPR_CFG_WORDS*4];   // Configuration bytes
   logic [7:0]   otp_mem  [ADPR_OTP_WORDS*4];   // OTP bytes
   logic [7:0]   data_mem [ADPR_DATA_WORDS*4];  // Data bytes
   logic [7:0]   slot_access_word [16];         // Per-slot flags
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < ADPR_CFG_WORDS*4; i++) cfg_mem[i] <= 8'(i);
      for (int i = 0; i < ADPR_OTP_WORDS*4; i++) otp_mem[i] <= 8'(i + 8'h40);
      for (int i = 0; i < ADPR_DATA_WORDS*4; i++) data_mem[i] <= 8'(i);
      // Slots 4-7 and 12-15 secret, 8-15 encrypted read, read key index = slot
      for (int i = 0; i < 16; i++) slot_access_word[i] <= {i[2], i[3], 6'(i)};
   end

   // ---------------------------------------------------------------
   // Scratch key
   // ---------------------------------------------------------------
   logic [255:0] scratch_key_register;      // Key bytes
   logic         sk_valid_q;                // Key valid
   logic         digest_generated_flag;     // Digest produced
   logic         scratch_key_origin_flag;   // 1: random origin
   logic [3:0]   scratch_key_slot_id;       // Digest source slot
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         scratch_key_register    <= '0;
         sk_valid_q              <= 1'b0;
         digest_generated_flag   <= 1'b0;
         scratch_key_origin_flag <= 1'b0;
         scratch_key_slot_id     <= 4'h0;
      end
      else if (digest_load)
      begin
         scratch_key_register  <= digest_value;
         digest_generated_flag <= 1'b1;
         scratch_key_slot_id   <= digest_slot;
      end
      else if (nonce_load)
      begin
         scratch_key_register    <= nonce_value;
         sk_valid_q              <= 1'b1;
         digest_generated_flag   <= 1'b0;
         scratch_key_origin_flag <= !nonce_passthru;
      end
   end

   // ---------------------------------------------------------------
   // Decode (continuous)
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ADPR_S_IDLE = 2'b00,
      ADPR_S_SEND = 2'b01,
      ADPR_S_OFF  = 2'b10
   } adpr_state_type;
   adpr_state_type state_q;

   wire take     = bus.cmd_valid && bus.cmd_ready;
   wire [7:0] op = bus.cmd_opcode;
   wire [7:0] p1 = bus.cmd_param1;
   wire [15:0] p2 = bus.cmd_param2;
   wire is_pause = (op == ADPR_OP_PAUSE);
   wire is_rand  = (op == ADPR_OP_RANDOM);
   wire is_read  = (op == ADPR_OP_READ);
   wire long_rd  = p1[ADPR_SIZE_BIT];
   wire [1:0] zone = p1[1:0];
   wire [15:0] word = long_rd ? {p2[15:3], 3'h0} : p2;
   wire [3:0]  slot = word[6:3];
   wire [7:0]  saw  = slot_access_word[slot];
   wire sec_f  = saw[ADPR_SC_SECRET];
   wire enc_f  = saw[ADPR_SC_ENCRD];
   wire [3:0] rkey = saw[ADPR_SC_RKEY_LO +: 4];
   // Parameter
   wire bad_param = (is_pause && p2 != 16'h0000)
                 || (is_rand && (p1[7:1] != 7'h00 || p2 != 16'h0000))
                 || (is_read && (p1[6:2] != 5'h00 || zone == 2'h3))
                 || !(is_pause || is_rand || is_read);
   wire cfg_err  = (word >= 16'(ADPR_CFG_WORDS)) || (word == 16'h0000 && !long_rd);
   wire otp_err  = !otp_locked
                || (word >= 16'(ADPR_OTP_WORDS))
                || (otp_zone_policy != 8'h00 && word < 16'h0002 && !long_rd)
                || (otp_zone_policy != 8'h00 && long_rd && word == 16'h0000)
                || (otp_zone_policy == ADPR_OTP_LEGACY && long_rd);
   wire key_ok   = sk_valid_q && digest_generated_flag
                && scratch_key_slot_id == rkey && scratch_key_origin_flag;
   wire data_err = !data_locked || (word >= 16'(ADPR_DATA_WORDS))
                || (sec_f && !long_rd) || (sec_f && !enc_f)
                || (enc_f && !key_ok);
   wire read_err = (zone == ADPR_ZONE_CFG)  ? cfg_err :
                   (zone == ADPR_ZONE_OTP)  ? otp_err : data_err;
   // ---------------------------------------------------------------
   // Seed and generator
   // ---------------------------------------------------------------
   logic [31:0] seed_q;        // Shared seed, also driven out on seed_out
   logic [31:0] gen_q;         // Running generator state
   int unsigned life_q;        // Remaining seed refreshes
   logic [255:0] buf_q;        // Answer bytes
   logic [5:0]   cnt_q;        // Bytes left
   logic         enc_q;        // Encrypted answer
   assign seed_out = seed_q;
   // Worn seed: only a refresh request is refused, keeping the seed still works
   wire seed_dead = is_rand && !p1[ADPR_MODE_NOUPD] && (life_q == 0);
   wire [31:0] mix = {gen_q[30:0], gen_q[31] ^ gen_q[21] ^ gen_q[1] ^ gen_q[0]}
                   ^ entropy;

   // ---------------------------------------------------------------
   // Command sequencer
   // ---------------------------------------------------------------
   assign bus.cmd_ready = (state_q == ADPR_S_IDLE);
   assign bus.rsp_valid = (state_q == ADPR_S_SEND);
   assign bus.rsp_byte  = buf_q[7:0] ^ (enc_q ? scratch_key_register[8*(32-cnt_q) +: 8]
                                              : 8'h00);
   assign bus.rsp_last  = (state_q == ADPR_S_SEND) && (cnt_q == 6'd1);
   assign idle          = (state_q == ADPR_S_OFF);

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_q <= ADPR_S_IDLE;
         seed_q  <= 32'h0000_0001;
         gen_q   <= 32'h0000_0001;
         life_q  <= SEED_LIFE;
         buf_q   <= '0;
         cnt_q   <= 6'd0;
         enc_q   <= 1'b0;
      end
      else
      begin
         gen_q <= mix;
         unique case (state_q)
            ADPR_S_IDLE:
               if (take)
               begin
                  state_q <= ADPR_S_SEND;
                  cnt_q   <= 6'd1;
                  enc_q   <= 1'b0;
                  if (bad_param)
                     buf_q[7:0] <= ADPR_ERR_PARSE;
                  else if (is_pause && p1 != unit_select)
                     state_q <= ADPR_S_OFF;
                  else if (is_pause)
                     buf_q[7:0] <= ADPR_OK;
                  else if (seed_dead)
                     buf_q[7:0] <= ADPR_ERR_EXEC;
                  else if (is_rand)
                  begin
                     cnt_q <= 6'(ADPR_LONG);
                     for (int i = 0; i < 32; i++)
                        buf_q[8*i +: 8] <= !config_locked
                           ? ((i % 4) < 2 ? ADPR_TEST_HI : ADPR_TEST_LO)
                           : mix[8*(i%4) +: 8] ^ seed_q[8*((i+1)%4) +: 8] ^ 8'(i);
                     if (!p1[ADPR_MODE_NOUPD] && config_locked)
                     begin
                        seed_q <= seed_q ^ mix;
                        life_q <= life_q - 1;
                     end
                  end
                  else if (read_err)
                     buf_q[7:0] <= ADPR_ERR_EXEC;
                  else
                  begin
                     cnt_q <= long_rd ? 6'(ADPR_LONG) : 6'(ADPR_SHORT);
                     enc_q <= (zone == ADPR_ZONE_DATA) && enc_f;
                     for (int i = 0; i < 32; i++)
                        buf_q[8*i +: 8] <=
                           (zone == ADPR_ZONE_CFG) ? cfg_mem[(4*word + i) % (ADPR_CFG_WORDS*4)] :
                           (zone == ADPR_ZONE_OTP) ? otp_mem[(4*word + i) % (ADPR_OTP_WORDS*4)] :
                                                     data_mem[(4*word + i) % (ADPR_DATA_WORDS*4)];
                  end
               end
            ADPR_S_SEND:
            begin
               buf_q <= buf_q >> 8;
               cnt_q <= cnt_q - 6'd1;
               if (cnt_q == 6'd1)
                  state_q <= ADPR_S_IDLE;
            end
            ADPR_S_OFF:
               state_q <= ADPR_S_OFF;   // Idle until reset (wake not modelled)
            default:
               state_q <= ADPR_S_IDLE;
         endcase
      end
   end
endmodule

// File: design/adpr_host.sv
/*
 Host end: forms commands from a user request and gathers answer bytes.
 Assumes the device end is joined through adpr_if on the same clock.
*/
module adpr_host
   import adpr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   adpr_if.host             bus,
   input  wire logic        req_valid,   // User asks for a command
   input  wire logic [7:0]  req_opcode,  // Opcode
   input  wire logic [7:0]  req_param1,  // Selector, mode or zone
   input  wire logic [15:0] req_param2,  // Address (read only)
   output logic             req_ready,   // Request accepted
   output logic             byte_valid,  // Answer byte strobe
   output logic [7:0]       byte_data,   // Answer byte
   output logic             byte_last    // Final answer byte
);
   // ---------------------------------------------------------------
   // Command holding register
   // ---------------------------------------------------------------
   logic        pend_q;    // Command outstanding
   logic [7:0]  op_q;
   logic [7:0]  p1_q;
   logic [15:0] p2_q;
   wire  is_read = (req_opcode == ADPR_OP_READ);
   assign req_ready      = !pend_q;
   assign bus.cmd_valid  = pend_q;
   assign bus.cmd_opcode = op_q;
   assign bus.cmd_param1 = p1_q;
   assign bus.cmd_param2 = p2_q;

   // Capture; idle and random send a zero second parameter
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pend_q <= 1'b0;
         op_q   <= 8'h00;
         p1_q   <= 8'h00;
         p2_q   <= 16'h0000;
      end
      else if (req_valid && !pend_q)
      begin
         pend_q <= 1'b1;
         op_q   <= req_opcode;
         p1_q   <= req_param1;
         p2_q   <= is_read ? req_param2 : 16'h0000;
      end
      else if (bus.cmd_ready)
         pend_q <= 1'b0;
   end

   // Answer bytes registered for the user
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         byte_valid <= 1'b0;
         byte_data  <= 8'h00;
         byte_last  <= 1'b0;
      end
      else
      begin
         byte_valid <= bus.rsp_valid;
         byte_data  <= bus.rsp_byte;
         byte_last  <= bus.rsp_valid && bus.rsp_last;
      end
   end
endmodule

// File: tb/adpr_sva.sv
/*
 Checker for the command/answer carrier between host end and device end.
 Assumes one clock, synchronous active-high reset, and the device's unit-select byte as SEL.
*/
module adpr_sva
   import adpr_pkg::*;
#(
   parameter logic [7:0] SEL = 8'h5A        // Unit-select byte of the device
)(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        cmd_valid,
   input wire logic        cmd_ready,
   input wire logic [7:0]  cmd_opcode,
   input wire logic [7:0]  cmd_param1,
   input wire logic [15:0] cmd_param2,
   input wire logic        rsp_valid,
   input wire logic [7:0]  rsp_byte,
   input wire logic        rsp_last
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------
   // Helper logic
   // ----------------------------------------------------------
   logic       take;     // Command accepted at this edge
   logic       bad_par;  // Some must-be-zero field is set
   logic       rd;       // Read command on the carrier
   logic [5:0] cnt_q;    // Bytes already sent of this answer
   logic [5:0] len_q;    // Length a data answer must have
   assign take = cmd_valid && cmd_ready;
   assign rd = take && cmd_opcode == ADPR_OP_READ;
   assign bad_par = (cmd_opcode == ADPR_OP_PAUSE && cmd_param2 != 16'h0000)
      || (cmd_opcode == ADPR_OP_RANDOM && (cmd_param1[7:1] != 7'h00 || cmd_param2 != 16'h0000))
      || (cmd_opcode == ADPR_OP_READ && cmd_param1[6:2] != 5'h00);
   // Byte counter; error answers are one byte, so they end at zero
   always_ff @(posedge clk)
   begin
      if (srst)
         cnt_q <= 6'h00;
      else if (rsp_valid)
         cnt_q <= rsp_last ? 6'h00 : cnt_q + 6'h01;
   end
   // Length latched at take, since the command may change afterwards
   always_ff @(posedge clk)
   begin
      if (take)
         len_q <= (rd && !cmd_param1[ADPR_SIZE_BIT]) ? 6'h04 : 6'h20;
   end
   // ----------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   AST_PAUSE_OK: assert property (take && cmd_opcode == ADPR_OP_PAUSE && !bad_par
      && cmd_param1 == SEL |=> rsp_valid && rsp_last && rsp_byte == ADPR_OK)
      else $error("pause match answer wrong");
   AST_PAUSE_MISS: assert property (take && cmd_opcode == ADPR_OP_PAUSE && !bad_par
      && cmd_param1 != SEL |=> !rsp_valid [*8])
      else $error("pause mismatch answered");
   AST_PARAM_ERR: assert property (take && bad_par
      |=> rsp_valid && rsp_last && rsp_byte == ADPR_ERR_PARSE)
      else $error("reserved bits not refused");
   AST_ZONE_CODE: assert property (rd && !bad_par && cmd_param1[1:0] == 2'h3
      |=> rsp_valid && rsp_last && rsp_byte == ADPR_ERR_PARSE)
      else $error("zone code three not refused");
   AST_CFG_WORD0: assert property (rd && cmd_param1 == 8'h00 && cmd_param2 == 16'h0000
      |=> rsp_valid && rsp_last && rsp_byte == ADPR_ERR_EXEC)
      else $error("unreadable word returned");
   AST_CFG_RANGE: assert property (rd && cmd_param1 == 8'h00 && cmd_param2 >= 16'h0016
      |=> rsp_valid && rsp_last && rsp_byte == ADPR_ERR_EXEC)
      else $error("address beyond zone accepted");
   AST_ANSWER_NEXT: assert property (take && cmd_opcode != ADPR_OP_PAUSE |=> rsp_valid)
      else $error("answer late");
   AST_BURST_CONT: assert property (rsp_valid && !rsp_last |=> rsp_valid)
      else $error("answer broken off");
   AST_LENGTH: assert property (rsp_valid && rsp_last && cnt_q != 6'h00
      |-> cnt_q + 6'h01 == len_q)
      else $error("answer length wrong");
endmodule

// File: tb/auth_device_pause_random_read_tb.sv
/*
 Self-checking bench: host end and device end joined by the carrier.
 Assumes the design files and package are compiled first.
*/
module auth_device_pause_random_read_tb
   import adpr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] SEL = 8'h5A;   // Unit-select byte under test
   logic         clk;
   logic         srst;
   logic         config_locked, otp_locked, data_locked;  // Zone locks
   logic [7:0]   otp_zone_policy;    // OTP policy byte
   logic [31:0]  entropy = 32'h0000_0000; // Walking entropy word
   logic [31:0]  seed_out, seed_keep;     // Seed seen, and kept for comparison
   logic         nonce_load, nonce_passthru, digest_load;
   logic [3:0]   digest_slot;
   logic [255:0] nonce_value, digest_value;
   logic         idle;
   logic         req_valid, req_ready, byte_valid, byte_last;
   logic [7:0]   req_opcode, req_param1, byte_data;
   logic [15:0]  req_param2;
   logic [7:0]   got[$];             // Bytes of the last answer
   int           fail_count, checks;
   adpr_if bus_if ();
   adpr_device #(.SEED_LIFE(2)) adpr_device_i (.clk(clk), .srst(srst), .bus(bus_if.device),
      .unit_select(SEL), .config_locked(config_locked), .otp_locked(otp_locked),
      .data_locked(data_locked), .otp_zone_policy(otp_zone_policy), .entropy(entropy),
      .nonce_load(nonce_load), .nonce_passthru(nonce_passthru), .nonce_value(nonce_value),
      .digest_load(digest_load), .digest_slot(digest_slot), .digest_value(digest_value),
      .idle(idle), .seed_out(seed_out));
   adpr_host adpr_host_i (.clk(clk), .srst(srst), .bus(bus_if.host), .req_valid(req_valid),
      .req_opcode(req_opcode), .req_param1(req_param1), .req_param2(req_param2),
      .req_ready(req_ready), .byte_valid(byte_valid), .byte_data(byte_data),
      .byte_last(byte_last));
   adpr_sva #(.SEL(SEL)) adpr_sva_i (.clk(clk), .srst(srst), .cmd_valid(bus_if.cmd_valid),
      .cmd_ready(bus_if.cmd_ready), .cmd_opcode(bus_if.cmd_opcode),
      .cmd_param1(bus_if.cmd_param1), .cmd_param2(bus_if.cmd_param2),
      .rsp_valid(bus_if.rsp_valid), .rsp_byte(bus_if.rsp_byte), .rsp_last(bus_if.rsp_last));
   // ----------------------------------------------------------
   // Clock, entropy and watchdog
   // ----------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Entropy keeps moving so random answers are not constant
   always @(posedge clk)
      entropy <= entropy + 32'h9E3779B9;
   // About 30 commands of under 70 cycles each; far above that is a hang
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      summarize();
   end
   // ----------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------
   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] seen);
      checks++;
      if (seen !== exp)
      begin
         $display("unexpected %s expected %h seen %h", name, exp, seen);
         fail_count++;
      end
   endtask
   task automatic chk1(input string name, input logic exp, input logic seen);
      checks++;
      if (seen !== exp)
      begin
         $display("unexpected %s expected %b seen %b", name, exp, seen);
         fail_count++;
      end
   endtask
   // One request, then gather the answer; a silent device just times out
   task automatic xfer(input logic [7:0] op, input logic [7:0] p1, input logic [15:0] p2);
      int n;
      got.delete();
      @(posedge clk);
      req_opcode <= op;
      req_param1 <= p1;
      req_param2 <= p2;
      req_valid <= 1'b1;
      do @(posedge clk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      for (n = 0; n < 60; n++)
      begin
         @(posedge clk);
         if (byte_valid === 1'b1)
            got.push_back(byte_data);
         if (byte_valid === 1'b1 && byte_last === 1'b1)
            break;
      end
   endtask
   // Length, then bytes base, base+inc, ...; pat selects the test pattern
   task automatic want(input logic [7:0] base, input int n, input bit inc, input bit pat);
      int i;
      chk8("length", 8'(n), 8'(got.size()));
      for (i = 0; i < n; i++)
         chk8("byte", pat ? ((i % 4 < 2) ? ADPR_TEST_HI : ADPR_TEST_LO)
                          : base + (inc ? 8'(i) : 8'h00), got[i]);
   endtask
   // Nonce then digest, the order the key path needs; origin follows pass
   task automatic load_key(input logic pass, input logic [3:0] slot);
      @(posedge clk);
      nonce_passthru <= pass;
      nonce_load <= 1'b1;
      @(posedge clk);
      nonce_load <= 1'b0;
      digest_slot <= slot;
      digest_load <= 1'b1;
      @(posedge clk);
      digest_load <= 1'b0;
   endtask
   task automatic summarize();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial
   begin
      {srst, config_locked, otp_locked, data_locked, nonce_load, digest_load} = 6'h20;
      {req_valid, nonce_passthru, otp_zone_policy, digest_slot} = '0;
      {req_opcode, req_param1, req_param2, nonce_value} = '0;
      digest_value = {32{8'h80}};   // Key bytes 0x80: XOR lifts bytes 0-31 by 0x80
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      xfer(ADPR_OP_PAUSE, SEL, 16'h0000);
      want(ADPR_OK, 1, 0, 0);
      chk1("idle", 1'b0, idle);
      // The host zeroes the second parameter, so the device still matches
      xfer(ADPR_OP_PAUSE, SEL, 16'h0001);
      want(ADPR_OK, 1, 0, 0);
      xfer(ADPR_OP_RANDOM, 8'h00, 16'h0000);
      want(8'h00, 32, 0, 1);
      xfer(ADPR_OP_RANDOM, 8'h02, 16'h0000);
      want(ADPR_ERR_PARSE, 1, 0, 0);
      xfer(ADPR_OP_READ, 8'h00, 16'h0001);
      want(8'h04, 4, 1, 0);
      xfer(ADPR_OP_READ, 8'h00, 16'h0000);
      want(ADPR_ERR_EXEC, 1, 0, 0);
      xfer(ADPR_OP_READ, 8'h00, 16'h0016);
      want(ADPR_ERR_EXEC, 1, 0, 0);
      xfer(ADPR_OP_READ, 8'h03, 16'h0000);
      want(ADPR_ERR_PARSE, 1, 0, 0);
      xfer(ADPR_OP_READ, 8'h04, 16'h0001);
      want(ADPR_ERR_PARSE, 1, 0, 0);
      xfer(ADPR_OP_READ, 8'h01, 16'h0002);
      want(ADPR_ERR_EXEC, 1, 0, 0);
      xfer(ADPR_OP_READ, 8'h02, 16'h0000);
      want(ADPR_ERR_EXEC, 1, 0, 0);
      // Lock every zone; read-only policy guards OTP words 0 and 1
      @(posedge clk);
      {config_locked, otp_locked, data_locked} <= 3'h7;
      otp_zone_policy <= ADPR_OTP_RO;
      xfer(ADPR_OP_READ, 8'h01, 16'h0002);
      want(8'h48, 4, 1, 0);
      xfer(ADPR_OP_READ, 8'h01, 16'h0000);
      want(ADPR_ERR_EXEC, 1, 0, 0);
      otp_zone_policy <= ADPR_OTP_LEGACY;
      xfer(ADPR_OP_READ, 8'h81, 16'h0000);
      want(ADPR_ERR_EXEC, 1, 0, 0);
      xfer(ADPR_OP_READ, 8'h01, 16'h0000);
      want(8'h40, 4, 1, 0);
      xfer(ADPR_OP_READ, 8'h82, 16'h0009);
      want(8'h20, 32, 1, 0);
      // Slot 8 reads encrypted with key slot 8; no key yet, then an input-origin key
      xfer(ADPR_OP_READ, 8'h82, 16'h0040);
      want(ADPR_ERR_EXEC, 1, 0, 0);
      load_key(1'b1, 4'h8);
      xfer(ADPR_OP_READ, 8'h82, 16'h0040);
      want(ADPR_ERR_EXEC, 1, 0, 0);
      load_key(1'b0, 4'h8);
      xfer(ADPR_OP_READ, 8'h82, 16'h0040);
      want(8'h80, 32, 1, 0);
      xfer(ADPR_OP_READ, 8'h82, 16'h0048);
      want(ADPR_ERR_EXEC, 1, 0, 0);
      xfer(ADPR_OP_READ, 8'h02, 16'h0060);
      want(ADPR_ERR_EXEC, 1, 0, 0);
      xfer(ADPR_OP_READ, 8'h82, 16'h0020);
      want(ADPR_ERR_EXEC, 1, 0, 0);
      // Seed life is two refreshes; keeping the seed never wears it
      seed_keep = seed_out;
      xfer(ADPR_OP_RANDOM, 8'h01, 16'h0000);
      chk8("length", 8'h20, 8'(got.size()));
      chk1("seed kept", 1'b1, seed_out === seed_keep);
      repeat (2)
      begin
         xfer(ADPR_OP_RANDOM, 8'h00, 16'h0000);
         chk8("length", 8'h20, 8'(got.size()));
      end
      xfer(ADPR_OP_RANDOM, 8'h00, 16'h0000);
      want(ADPR_ERR_EXEC, 1, 0, 0);
      xfer(ADPR_OP_RANDOM, 8'h01, 16'h0000);
      chk8("length", 8'h20, 8'(got.size()));
      xfer(ADPR_OP_PAUSE, 8'h11, 16'h0000);
      want(8'h00, 0, 0, 0);
      chk1("idle", 1'b1, idle);
      // Only a reset brings an idled device back
      @(posedge clk);
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk1("idle", 1'b0, idle);
      xfer(ADPR_OP_PAUSE, SEL, 16'h0000);
      want(ADPR_OK, 1, 0, 0);
      summarize();
   end
endmodule
